// [hdl/bus_unit.sv]
`timescale 1ns/1ps
// Function
// [RQ1] Cycles measured strobe-to-ready and ready-to-ready
// [RQ2] Address and control held from first wait
// [RQ3] Next-address in wait allows following strobe
// [RQ4] Each ready retires oldest, count drops
// [RQ5] Write drives byte enables and data
// [RQ6] Repeated next-address sustains three cycles
// [RQ7] Write data only after earlier cycles retire
// [RQ8] Write after read waits one clock
// [RQ9] Memory delays ready after read-write
// [RQ10] Write without prior read needs no wait
// [RQ11] Boot width strapped at reset release
// [RQ12] Boot code fetched bytewise on low lane
// [RQ13] Low byte enables carry low address
// [RQ14] Boot code cached only while cacheable
// [RQ15] No pipelining in byte boot mode
// [RQ16] Execution starts at trap address
// [RQ17] Board maps boot ROM over RAM
// [RQ18] Board port unmaps boot ROM
// [RQ19] Software clears boot mode until reset
// [RQ20] Next-address ignored during own strobe
// [RQ21] Next-address latched, one clock suffices
// [RQ22] No next-address with nothing outstanding
// [RQ23] Data moves in cycle start order
// [RQ24] Never a fourth outstanding cycle
module bus_unit
    import bus_unit_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_req_valid,
    input  wire logic                 i_req_write,
    input  wire logic                 i_req_code,
    input  wire logic [ADDR_HI:ADDR_LO] i_req_addr,
    input  wire logic [LOW_W-1:0]     i_req_low_addr,
    input  wire logic [LANES-1:0]     i_req_byte_en,
    input  wire logic [DATA_W-1:0]    i_req_wdata,
    input  wire logic                 i_req_same_page,
    input  wire logic                 i_req_page_table,
    output logic                      o_req_ready,
    output logic                      o_rd_valid,
    output logic [DATA_W-1:0]         o_rd_data,
    output logic                      o_rd_code_fill,
    input  wire logic                 i_clear_boot_mode,
    output logic                      o_byte_boot_mode,
    output logic [31:0]               o_start_address,
    output logic                      o_address_strobe_n,
    output logic [ADDR_HI:ADDR_LO]    o_addr,
    output logic                      o_write_not_read,
    output logic [LANES-1:0]          o_byte_lane_enable_n,
    output logic                      o_same_page_hint_n,
    output logic                      o_page_table_access_n,
    input  wire logic [DATA_W-1:0]    i_data,
    output logic [DATA_W-1:0]         o_data,
    output logic                      o_data_oe,
    input  wire logic                 i_ready_n,
    input  wire logic                 i_next_address_req_n,
    input  wire logic                 i_cacheable_in_n,
    input  wire logic                 i_irq_boot_width_pin
);
    // Strobe states, decoded in several places
    function automatic logic is_start(input bus_state_type s);
        is_start = (s == ST_T1) || (s == ST_T2) || (s == ST_T3);
    endfunction

    // Start state for the count after the new cycle
    function automatic bus_state_type start_state(input logic [CNT_W-1:0] c);
        case (c)
            CNT_ONE: start_state = ST_T1;
            CNT_TWO: start_state = ST_T2;
            default: start_state = ST_T3;
        endcase
    endfunction

    // Wait state for a count, remembering a granted next address at one or two cycles in flight
    function automatic bus_state_type wait_state(input logic [CNT_W-1:0] c, input logic na);
        case (c)
            CNT_ONE: wait_state = na ? ST_T12 : ST_T11;
            CNT_TWO: wait_state = na ? ST_T22 : ST_T21;
            default: wait_state = ST_T31;
        endcase
    endfunction

    cycle_queue_if    q ();                    // Cycles in flight
    bus_state_type    state;                   // Bus state
    bus_state_type    next_state;              // Bus state after this edge
    logic             na_pending;              // Next address granted, not yet used
    logic             na_seen;                 // Next address sampled this clock
    logic             retire;                  // Ready for the oldest cycle
    logic             start;                   // New cycle begins next clock
    logic [CNT_W-1:0] next_count;              // Count after this edge
    logic             last_read;               // Last retired cycle was a read
    logic             strap_taken;             // Boot width already sampled
    logic             boot_code;               // Byte-wide code request

    cycle_queue u_queue (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .q        (q)
    );

    // Ready only counts while something is in flight [RQ1]
    assign retire = !i_ready_n && q.head_valid; // [RQ4]
    // Strobe clocks and idle bus never grant pipelining [RQ20] [RQ22]
    assign na_seen = !i_next_address_req_n && !is_start(state) && q.head_valid
                     && !o_byte_boot_mode;
    // Idle bus, or a latched grant with room for one more [RQ3] [RQ24]
    assign start = i_req_valid && !is_start(state)
                   && (q.count == CNT_NONE
                       || (na_pending && (q.count != CNT_THREE || retire)
                           && !o_byte_boot_mode)); // [RQ6] [RQ15]
    assign o_req_ready = start;
    assign next_count  = q.count + CNT_W'(start) - CNT_W'(retire);
    assign boot_code   = o_byte_boot_mode && i_req_code;

    assign q.push           = start;
    assign q.push_item      = '{write: i_req_write, code: i_req_code, data: i_req_wdata};
    assign q.pop            = retire;
    assign o_start_address  = TRAP_ADDR;       // [RQ16]

    // State follows the count; a start that meets a ready lands one level lower
    always_comb
    begin
        if (start)
            next_state = start_state(next_count); // [RQ4]
        else if (next_count == CNT_NONE)
            next_state = ST_IDLE;
        else
            next_state = wait_state(next_count, na_pending || na_seen); // [RQ6]
    end

    // Bus state register
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Grant is remembered so a single clock of next address is enough
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            na_pending <= 1'b0;
        else if (start || next_count == CNT_NONE)
            na_pending <= 1'b0;
        else if (na_seen)
            na_pending <= 1'b1;                // [RQ21]
    end

    // Address and control launch with the strobe and hold through the waits
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_address_strobe_n    <= 1'b1;
            o_addr                <= '0;
            o_write_not_read      <= 1'b0;
            o_byte_lane_enable_n  <= '1;
            o_same_page_hint_n    <= 1'b1;
            o_page_table_access_n <= 1'b1;
        end
        else
        begin
            o_address_strobe_n <= !start;
            if (start)
            begin
                o_addr                <= i_req_addr;       // [RQ2]
                o_write_not_read      <= i_req_write;
                o_same_page_hint_n    <= !i_req_same_page;
                o_page_table_access_n <= !i_req_page_table;
                // Boot code reads turn the low enables into address bits
                if (boot_code)
                    o_byte_lane_enable_n <= {~i_req_byte_en[LANES-1:LOW_W],
                                             i_req_low_addr}; // [RQ13]
                else
                    o_byte_lane_enable_n <= ~i_req_byte_en; // [RQ5]
            end
        end
    end

    // Write data goes out only for the oldest cycle; a read just before
    // costs one clock so the reader has released the bus
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_data    <= '0;
            o_data_oe <= 1'b0;
            last_read <= 1'b0;
        end
        else
        begin
            o_data    <= q.head.data;          // [RQ5]
            o_data_oe <= q.head_valid && q.head.write && !retire      // [RQ7]
                         && !(last_read && q.head_fresh);             // [RQ8]
            if (retire)
                last_read <= !q.head.write;
        end
    end

    // Read data capture, in start order
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rd_valid     <= 1'b0;
            o_rd_data      <= '0;
            o_rd_code_fill <= 1'b0;
        end
        else
        begin
            o_rd_valid <= retire && !q.head.write; // [RQ23]
            // Boot code arrives one byte at a time on the low lane
            if (o_byte_boot_mode && q.head.code)
                o_rd_data <= {{(DATA_W-BYTE_W){1'b0}}, i_data[BYTE_W-1:0]}; // [RQ12]
            else
                o_rd_data <= i_data;
            o_rd_code_fill <= retire && !q.head.write && q.head.code
                              && !i_cacheable_in_n; // [RQ14]
        end
    end

    // Strap caught at the first edge after release; only software clears it
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            strap_taken      <= 1'b0;
            o_byte_boot_mode <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_taken      <= 1'b1;
            o_byte_boot_mode <= i_irq_boot_width_pin; // [RQ11]
        end
        else if (i_clear_boot_mode)
            o_byte_boot_mode <= 1'b0;          // [RQ19]
    end

    // Checks
    max_outstanding_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ24]
        q.count == CNT_THREE && !retire |=> q.count == CNT_THREE)
        else $error("fourth cycle started");
    strobe_single_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ3]
        !o_address_strobe_n |=> o_address_strobe_n)
        else $error("strobe held two clocks");
    strobe_grant_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ21]
        start && q.count != CNT_NONE |-> na_pending)
        else $error("pipelined start without grant");
    na_ignored_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ20]
        is_start(state) && !na_pending |=> !na_pending)
        else $error("next address taken during strobe");
    retire_count_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ4]
        retire && !start |=> q.count == $past(q.count) - CNT_ONE)
        else $error("ready did not retire a cycle");
    third_meets_ready_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ4]
        start && retire && q.count == CNT_TWO |=> state == ST_T2)
        else $error("wrong state after overlapped ready");
    boot_no_pipe_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ15]
        o_byte_boot_mode && start |-> q.count == CNT_NONE)
        else $error("pipelined cycle in byte boot mode");
    boot_sticky_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ19]
        strap_taken && !o_byte_boot_mode |=> !o_byte_boot_mode)
        else $error("byte boot mode came back");
    wr_after_rd_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ8]
        last_read && q.head_fresh && q.head.write |=> !o_data_oe)
        else $error("write data without extra clock");
    data_owner_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ7]
        o_data_oe |-> q.head_valid && q.head.write)
        else $error("write data before earlier cycles done");
    addr_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RQ2]
        !start |=> $stable(o_addr) && $stable(o_write_not_read))
        else $error("address changed during wait");

    three_out_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        state == ST_T3 ##1 state == ST_T31);
    rd_then_wr_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        retire && !q.head.write ##1 q.head.write ##[1:3] o_data_oe);
    boot_fetch_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        o_byte_boot_mode && o_rd_code_fill);
    sustain_three_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        state == ST_T31 ##1 state == ST_T3);
endmodule // bus_unit

// [hdl/bus_unit_pkg.sv]
package bus_unit_pkg;
    // Bus geometry
    localparam int DATA_W  = 64;               // Data bus width
    localparam int LANES   = 8;                // Byte lanes on the data bus
    localparam int ADDR_HI = 31;               // Top address bit on the pins
    localparam int ADDR_LO = 3;                // Lowest address bit on the pins
    localparam int LOW_W   = 3;                // Byte offset width inside a word
    localparam int BYTE_W  = 8;                // Width of the boot code lane
    localparam int DEPTH   = 3;                // Most cycles in flight
    localparam int CNT_W   = 2;                // Width of the outstanding count

    // Outstanding counts
    localparam logic [CNT_W-1:0] CNT_NONE  = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 2'h1;
    localparam logic [CNT_W-1:0] CNT_TWO   = 2'h2;
    localparam logic [CNT_W-1:0] CNT_THREE = 2'h3;

    // Execution start after reset
    localparam logic [31:0] TRAP_ADDR = 32'hffffff00;

    // Bus states, Gray coded along idle, start, wait, wait with next address granted, pipelined start, ...
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_T1   = 4'h1,
        ST_T11  = 4'h3,
        ST_T12  = 4'h2,
        ST_T2   = 4'h6,
        ST_T21  = 4'h7,
        ST_T22  = 4'h5,
        ST_T3   = 4'h4,
        ST_T31  = 4'hc
    } bus_state_type;

    // One bus cycle as remembered until its ready
    typedef struct packed {
        logic              write;              // Write cycle
        logic              code;               // Instruction fetch
        logic [DATA_W-1:0] data;               // Write data
    } cycle_type;
endpackage

// [hdl/cycle_queue.sv]
`timescale 1ns/1ps
module cycle_queue
    import bus_unit_pkg::*;
(
    input  wire logic   i_clock,
    input  wire logic   i_arst_n,
    cycle_queue_if.owner q
);
    // Pointer step with wrap at the queue depth
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] p);
        step = (p == CNT_W'(DEPTH - 1)) ? CNT_NONE : p + CNT_ONE;
    endfunction

    cycle_type        entry [DEPTH];           // Cycle storage
    logic [CNT_W-1:0] rd_ptr;                  // Oldest entry
    logic [CNT_W-1:0] wr_ptr;                  // Next free entry
    logic [CNT_W-1:0] count;                   // Occupancy
    logic             fresh;                   // Head replaced at last edge

    // Entries are written in start order and read in the same order [RQ23]
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    entry[g] <= '0;
                else if (q.push && wr_ptr == CNT_W'(g))
                    entry[g] <= q.push_item;
            end
        end
    endgenerate

    // Pointers and occupancy
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rd_ptr <= CNT_NONE;
            wr_ptr <= CNT_NONE;
            count  <= CNT_NONE;
            fresh  <= 1'b0;
        end
        else
        begin
            if (q.push)
                wr_ptr <= step(wr_ptr);
            if (q.pop)
                rd_ptr <= step(rd_ptr);
            count <= count + CNT_W'(q.push) - CNT_W'(q.pop);
            // A new head appears on a retire or on a push into an empty queue
            fresh <= q.pop || (q.push && count == CNT_NONE);
        end
    end

    assign q.head       = entry[rd_ptr];
    assign q.head_valid = (count != CNT_NONE);
    assign q.head_fresh = fresh;
    assign q.count      = count;
endmodule // cycle_queue

// [hdl/cycle_queue_if.sv]
`timescale 1ns/1ps
interface cycle_queue_if;
    import bus_unit_pkg::*;
    logic              push;                   // Cycle started
    cycle_type         push_item;              // Started cycle
    logic              pop;                    // Oldest cycle retired
    cycle_type         head;                   // Oldest cycle in flight
    logic              head_valid;             // Any cycle in flight
    logic              head_fresh;             // Head changed at last edge
    logic [CNT_W-1:0]  count;                  // Cycles in flight

    modport owner (input push, push_item, pop, output head, head_valid, head_fresh, count);
    modport user  (output push, push_item, pop, input head, head_valid, head_fresh, count);
endinterface

// [testbench/mem_partner.sv]
`timescale 1ns/1ps
module mem_partner
    import bus_unit_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_arst_n,
    input  wire logic [3:0]             i_lat,       // Wait clocks before ready
    input  wire logic                   i_pipe,      // Offer next-address at all
    input  wire logic                   i_rom_on,    // Boot ROM over upper RAM
    input  wire logic [LOW_W-1:0]       i_low,       // Low address on the lane enables
    input  wire logic                   i_strobe_n,
    input  wire logic [ADDR_HI:ADDR_LO] i_addr,
    input  wire logic                   i_write,
    input  wire logic [DATA_W-1:0]      i_data,
    input  wire logic                   i_data_oe,
    output logic                        o_ready_n,
    output logic                        o_next_address_req_n,
    output logic [DATA_W-1:0]           o_data
);
    logic [DATA_W-1:0]      mem [logic [ADDR_HI:ADDR_LO]]; // Words written so far
    logic                   q_wr [$];                    // Direction per cycle in flight
    logic [ADDR_HI:ADDR_LO] q_ad [$];                    // Address per cycle in flight
    logic [LOW_W-1:0]       q_lo [$];                    // Low address per cycle
    int                     age;                         // Clocks the oldest has waited

    // Latch each new cycle and retire the oldest on ready
    always @(posedge i_clock or negedge i_arst_n)
        if (!i_arst_n)
        begin
            q_wr.delete();
            q_ad.delete();
            q_lo.delete();
            age = 0;
        end
        else
        begin
            age++;
            if (!o_ready_n && q_wr.size() > 0)
            begin
                if (q_wr[0])
                    mem[q_ad[0]] = i_data;     // Write data taken at its ready
                void'(q_wr.pop_front());
                void'(q_ad.pop_front());
                void'(q_lo.pop_front());
                age = 0;
            end
            if (i_strobe_n === 1'b0)           // Address and control taken
            begin
                if (q_wr.size() == 0)
                    age = 0;
                q_wr.push_back(i_write);
                q_ad.push_back(i_addr);
                q_lo.push_back(i_low);
            end
        end

    // Answer half a clock after the edge, as a real controller would
    always @(negedge i_clock or negedge i_arst_n)
        if (!i_arst_n)
        begin
            o_ready_n <= 1'b1;
            o_next_address_req_n <= 1'b1;
            o_data <= '0;
        end
        else
        begin
            // One-clock grants, only with cycles in flight
            o_next_address_req_n <= !(i_pipe && q_wr.size() > 0 && $urandom_range(1));
            // A write waits until its data is driven, which absorbs the read gap
            if (q_wr.size() > 0 && age >= int'(i_lat) && (!q_wr[0] || i_data_oe === 1'b1))
            begin
                o_ready_n <= 1'b0;
                if (i_rom_on && q_ad[0][ADDR_HI]) // ROM byte on the low lane
                    o_data <= {56'h0, ~{q_ad[0][7:3], q_lo[0]}};
                else
                    o_data <= mem.exists(q_ad[0]) ? mem[q_ad[0]]
                              : {~{q_ad[0], 3'h0}, q_ad[0], 3'h0};
            end
            else
            begin
                o_ready_n <= 1'b1;
                o_data <= ~o_data;             // Bus not held: never leave the old word
            end
        end
endmodule // mem_partner

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench
    import bus_unit_pkg::*;
();
    typedef struct packed {
        logic write, code, sp, pt;
        logic [ADDR_HI:ADDR_LO] addr;
        logic [LOW_W-1:0] low;
        logic [LANES-1:0] be;
        logic [DATA_W-1:0] wdata;
    } req_type;

    logic                   i_clock, i_arst_n, i_req_valid, i_req_write, i_req_code;
    logic                   i_req_same_page, i_req_page_table, i_clear_boot_mode;
    logic                   i_cacheable_in_n, i_irq_boot_width_pin, i_ready_n;
    logic                   i_next_address_req_n, o_req_ready, o_rd_valid, o_rd_code_fill;
    logic                   o_byte_boot_mode, o_address_strobe_n, o_write_not_read;
    logic                   o_same_page_hint_n, o_page_table_access_n, o_data_oe, pipe;
    logic [ADDR_HI:ADDR_LO] i_req_addr, o_addr;
    logic [LOW_W-1:0]       i_req_low_addr;
    logic [LANES-1:0]       i_req_byte_en, o_byte_lane_enable_n;
    logic [DATA_W-1:0]      i_req_wdata, o_rd_data, i_data, o_data;
    logic [31:0]            o_start_address;
    logic [3:0]             lat;                      // Partner wait clocks
    logic [DATA_W-1:0]      bmem [logic [ADDR_HI:ADDR_LO]]; // Mirror of memory
    req_type                taken [$], fly [$], r;    // Taken requests, cycles on the bus
    logic [DATA_W-1:0]      exp_rd [$];               // Read words still due
    logic                   exp_fill [$], last_rd, boot, prev_oe;
    int                     fail_count, cmp_count, max_out, age;

    bus_unit dut_u (.i_clock, .i_arst_n, .i_req_valid, .i_req_write, .i_req_code, .i_req_addr,
        .i_req_low_addr, .i_req_byte_en, .i_req_wdata, .i_req_same_page, .i_req_page_table,
        .o_req_ready, .o_rd_valid, .o_rd_data, .o_rd_code_fill, .i_clear_boot_mode,
        .o_byte_boot_mode, .o_start_address, .o_address_strobe_n, .o_addr, .o_write_not_read,
        .o_byte_lane_enable_n, .o_same_page_hint_n, .o_page_table_access_n, .i_data, .o_data,
        .o_data_oe, .i_ready_n, .i_next_address_req_n, .i_cacheable_in_n, .i_irq_boot_width_pin);

    mem_partner mem_u (.i_clock, .i_arst_n, .i_lat(lat), .i_pipe(pipe),
        .i_strobe_n(o_address_strobe_n), .i_addr(o_addr), .i_write(o_write_not_read),
        .i_data(o_data), .i_data_oe(o_data_oe), .o_ready_n(i_ready_n),
        .i_rom_on(boot), .i_low(o_byte_lane_enable_n[LOW_W-1:0]),
        .o_next_address_req_n(i_next_address_req_n), .o_data(i_data));

    // Free-running 25 MHz clock
    initial
    begin
        i_clock = 0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Bus watcher: data phase, oldest retires on ready, new cycle, read return
    always @(posedge i_clock)
        if (i_arst_n)
        begin
            if (o_data_oe === 1'b1)
            begin
                check("oe_head", 1, fly.size() > 0 && fly[0].write);
                if (fly.size() > 0) check("wdata", fly[0].wdata, o_data);
                if (!prev_oe) check("oe_gap", 1 + last_rd, age);
            end
            if (!i_ready_n && fly.size() > 0)
            begin
                last_rd = !fly[0].write;
                void'(fly.pop_front());
                age = -1;
            end
            if (o_address_strobe_n === 1'b0)
            begin
                r = taken.pop_front();
                check("addr", r.addr, o_addr);
                check("ctl", {r.write, ~r.sp, ~r.pt},
                      {o_write_not_read, o_same_page_hint_n, o_page_table_access_n});
                if (r.write) check("be", 8'(~r.be), o_byte_lane_enable_n);
                if (boot && r.code) check("low", r.low, o_byte_lane_enable_n[2:0]);
                if (fly.size() == 0 && age >= 0)
                    age = 0;
                fly.push_back(r);
                max_out = (fly.size() > max_out) ? fly.size() : max_out;
                check("depth", 1, fly.size() <= 3);
            end
            if (o_rd_valid === 1'b1)
            begin
                check("rdata", exp_rd.pop_front(), o_rd_data);
                if (boot) check("fill", exp_fill.pop_front(), o_rd_code_fill);
                else void'(exp_fill.pop_front());
            end
            age++;
            prev_oe = o_data_oe;
        end

    task automatic do_reset(input logic strap);
        @(negedge i_clock);
        i_arst_n = 0;
        i_irq_boot_width_pin = strap;
        fly.delete();
        taken.delete();
        exp_rd.delete();
        exp_fill.delete();
        {last_rd, prev_oe, age, max_out} = '0;
        repeat (6) @(negedge i_clock);
        i_arst_n = 1;
        repeat (2) @(negedge i_clock);
    endtask

    // One request held until taken; expectation worked out from the mirror
    task automatic issue(input logic wr, input logic cd);
        req_type q;
        logic [DATA_W-1:0] w;
        int n;
        q = {wr, cd, 1'($urandom), 1'($urandom), 29'($urandom_range(7)), 3'($urandom),
             8'($urandom), $urandom, $urandom};
        q.addr[ADDR_HI] = cd; // Code sits in the boot ROM range
        @(negedge i_clock);
        {i_req_valid, i_req_write, i_req_code, i_req_same_page, i_req_page_table, i_req_addr,
         i_req_low_addr, i_req_byte_en, i_req_wdata} = {1'b1, q};
        n = 0;
        do begin @(posedge i_clock); n++; end while (o_req_ready !== 1'b1 && n < 40);
        if (n >= 40) check("taken", 1, 0);
        taken.push_back(q);
        w = bmem.exists(q.addr) ? bmem[q.addr] : {~{q.addr, 3'h0}, q.addr, 3'h0};
        if (wr)
            bmem[q.addr] = q.wdata;
        else
        begin
            exp_rd.push_back(boot && cd ? {56'h0, ~{q.addr[7:3], q.low}} : w);
            exp_fill.push_back(boot && cd && !i_cacheable_in_n);
        end
    endtask

    // A run of random requests, then wait until the bus is quiet
    task automatic burst(input int n, input logic p, input logic [3:0] l, input logic cd);
        @(negedge i_clock);
        pipe = p;
        lat = l;
        repeat (n) issue(!cd && 1'($urandom), cd);
        @(negedge i_clock);
        i_req_valid = 0;
        repeat (200) if (fly.size() + taken.size() + exp_rd.size() > 0) @(negedge i_clock);
        check("drained", 0, fly.size() + taken.size() + exp_rd.size());
    endtask

    // Watchdog well above the longest expected run
    initial
    begin
        repeat (30000) @(posedge i_clock);
        fail_count++;
        finish_test();
    end

    initial
    begin
        {i_req_valid, i_req_write, i_req_code, i_req_same_page, i_req_page_table} = '0;
        {i_req_addr, i_req_low_addr, i_req_byte_en, i_req_wdata, i_clear_boot_mode} = '0;
        {i_arst_n, i_irq_boot_width_pin, pipe, lat, boot} = '0;
        i_cacheable_in_n = 1;
        void'($urandom(69));
        do_reset(0);
        check("boot", 0, o_byte_boot_mode);
        check("start", 32'hffffff00, o_start_address);
        for (int l = 0; l < 4; l++) burst(10, 0, 4'(l), 0);
        burst(24, 1, 6, 0);
        check("three", 3, max_out);
        burst(30, 1, 4'($urandom_range(4)), 0);
        do_reset(1);
        boot = 1;
        check("boot", 1, o_byte_boot_mode);
        i_cacheable_in_n = 0;
        burst(8, 1, 3, 1);
        i_cacheable_in_n = 1;
        burst(8, 1, 3, 1);
        burst(8, 1, 3, 0);
        check("nopipe", 1, max_out);
        i_clear_boot_mode = 1;
        @(negedge i_clock);
        i_clear_boot_mode = 0;
        boot = 0; // Port write unmaps the boot ROM
        max_out = 0;
        @(negedge i_clock);
        check("cleared", 0, o_byte_boot_mode);
        burst(24, 1, 6, 0);
        check("stays", 0, o_byte_boot_mode);
        check("three", 3, max_out);
        finish_test();
    end
endmodule // testbench
